// [design/reactive_energy_pkg.sv]
// constants, register map and carrier types of the reactive energy accumulator
package reactive_energy_pkg;

    // ==========================================================
    // widths and timing
    localparam int  SAMPLE_W         = 24;
    localparam int  ACC_W            = 42;
    localparam int  UPPER_W          = 24;
    localparam int  UPPER_LSB        = ACC_W - UPPER_W;
    localparam int  COUNT_W          = 16;
    localparam real CLK_PERIOD_NS    = 100.0;
    localparam real SAMPLE_PERIOD_US = 230.4;
    localparam int  SAMPLE_CYCLES    = int'(SAMPLE_PERIOD_US * 1000.0 / CLK_PERIOD_NS);
    localparam int  SAMPLE_CNT_W     = 12;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFF_POWER_CONTROL_TWO = 8'h00;
    localparam logic [7:0] OFF_POWER_CONTROL_ONE = 8'h04;
    localparam logic [7:0] OFF_DIVIDER           = 8'h08;
    localparam logic [7:0] OFF_HALF_CYCLE_COUNT  = 8'h0c;
    localparam logic [7:0] OFF_ENERGY_UPPER      = 8'h10;
    localparam logic [7:0] OFF_ENERGY_READ_CLEAR = 8'h14;
    localparam logic [7:0] OFF_LINE_RESULT       = 8'h18;
    localparam logic [7:0] OFF_IRQ_REQUEST       = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK          = 8'h20;

    // ==========================================================
    // field positions
    localparam int BIT_TAMPER_SEL   = 0;
    localparam int BIT_ABSOLUTE_SEL = 1;
    localparam int BIT_NOLOAD_LO    = 2;
    localparam int BIT_CYCLE_DIS    = 0;
    localparam int BIT_CYCLE_END    = 0;
    localparam int BIT_HALF_FULL    = 1;
    localparam int BIT_OVERFLOW     = 2;
    localparam int FLAG_W           = 3;

    // ==========================================================
    // reset values
    localparam logic [3:0]         RST_POWER_CONTROL_TWO = 4'h0;
    localparam logic [7:0]         RST_DIVIDER           = 8'h01;
    localparam logic [COUNT_W-1:0] RST_HALF_CYCLE_COUNT  = 16'h0000;
    localparam logic [FLAG_W-1:0]  RST_IRQ_MASK          = 3'h7;

    // no-load thresholds as fractions of a full-scale sample (2^23)
    localparam logic [SAMPLE_W-1:0] NOLOAD_THR_1 = 24'd1258;
    localparam logic [SAMPLE_W-1:0] NOLOAD_THR_2 = 24'd629;
    localparam logic [SAMPLE_W-1:0] NOLOAD_THR_3 = 24'd310;

    typedef enum logic [1:0] {MODE_SIGNED, MODE_TAMPER, MODE_ABSOLUTE} accum_mode_e;
    typedef enum logic {LINE_WAIT, LINE_RUN} line_state_e;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] reactive;
        logic                       active_negative;
    } power_sample_s;

endpackage : reactive_energy_pkg

// [design/reactive_energy_accumulator.sv]
// reactive energy accumulator with line-cycle mode behind an ahb-lite slave
//
// Contract
// - add one scaled reactive sample to the accumulator every 230.4 us sample period.
// - accumulator is signed, 42 bits wide.
// - divide each sample by the 8-bit divider; zero acts as one.
// - absolute bit wins; only tamper bit selects anti-tamper; none selects signed.
// - signed mode adds positive samples and subtracts negative ones.
// - reset selects signed mode with tamper and absolute off.
// - samples below the no-load threshold are not accumulated.
// - anti-tamper mode signs the reactive sample by the active power sign.
// - absolute mode accumulates magnitudes, skipping no-load samples.
// - selected mode treatment applies to the pulse path too.
// - direction and no-load detection stay active in every mode.
// - energy pulse comes from gain-corrected power, treated per mode.
// - line periods start and stop on voltage zero crossings.
// - line period length comes from a 16-bit half-cycle count.
// - count elapsed sets cycle-end flag; unmasked interrupt holds until cleared.
// - next line period starts at once; result overwritten even if unread.
// - count write clears line result and accumulator; restart at next crossing.
// - line accumulation uses the same scaled sample as normal accumulation.
// - disable bit blocks cycle-end interrupt and count-write clearing.
// - upper 24 bits readable plainly and by a read that clears them.
// - half-full and overflow flags, each maskable as interrupt.
// - overflow wraps to most negative, underflow to most positive.
`timescale 1ns/100ps

module reactive_energy_accumulator
    import reactive_energy_pkg::*;
#(
    parameter logic [31:0] PULSE_THRESHOLD = 32'h0100_0000
)(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    input  wire power_sample_s power_in,
    input  wire logic          zero_cross,
    output logic               energy_pulse_output,
    output logic               reactive_negative,
    output logic               noload_active,
    output logic               energy_irq
);

    // ==========================================================
    // register state
    logic [3:0]               power_control_two;
    logic                     cycle_end_disable;
    logic [7:0]               reactive_energy_divider;
    logic [COUNT_W-1:0]       half_cycle_count;
    logic [FLAG_W-1:0]        irq_flags;
    logic [FLAG_W-1:0]        irq_mask;
    logic signed [ACC_W-1:0]  energy_acc;
    logic signed [ACC_W-1:0]  line_acc;
    logic [UPPER_W-1:0]       line_result;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    function automatic logic half_full(input logic [ACC_W-1:0] v);
        half_full = (v[ACC_W-1] != v[ACC_W-2]);
    endfunction : half_full

    // ==========================================================
    // ahb-lite slave: writes zero-wait, reads one wait state
    logic       wr_pend;
    logic       rd_pend;
    logic [7:0] dp_addr;
    logic       addr_ok;

    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            if (addr_ok)
                dp_addr <= haddr[7:0];
        end
    end

    logic wr_ctl2;
    logic wr_ctl1;
    logic wr_div;
    logic wr_hcc;
    logic wr_flags;
    logic wr_mask;
    logic rd_clear;

    assign wr_ctl2  = wr_pend && hit(dp_addr, OFF_POWER_CONTROL_TWO);
    assign wr_ctl1  = wr_pend && hit(dp_addr, OFF_POWER_CONTROL_ONE);
    assign wr_div   = wr_pend && hit(dp_addr, OFF_DIVIDER);
    assign wr_hcc   = wr_pend && hit(dp_addr, OFF_HALF_CYCLE_COUNT);
    assign wr_flags = wr_pend && hit(dp_addr, OFF_IRQ_REQUEST);
    assign wr_mask  = wr_pend && hit(dp_addr, OFF_IRQ_MASK);
    // the clearing read lands at the edge that loads hrdata
    assign rd_clear = rd_pend && hit(dp_addr, OFF_ENERGY_READ_CLEAR);

    logic [31:0] next_rdata;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (dp_addr)
            OFF_POWER_CONTROL_TWO: next_rdata = {28'h0, power_control_two};
            OFF_POWER_CONTROL_ONE: next_rdata = {31'h0, cycle_end_disable};
            OFF_DIVIDER:           next_rdata = {24'h0, reactive_energy_divider};
            OFF_HALF_CYCLE_COUNT:  next_rdata = {16'h0, half_cycle_count};
            OFF_ENERGY_UPPER:      next_rdata = {8'h0, energy_acc[ACC_W-1:UPPER_LSB]};
            OFF_ENERGY_READ_CLEAR: next_rdata = {8'h0, energy_acc[ACC_W-1:UPPER_LSB]};
            OFF_LINE_RESULT:       next_rdata = {8'h0, line_result};
            OFF_IRQ_REQUEST:       next_rdata = {29'h0, irq_flags};
            OFF_IRQ_MASK:          next_rdata = {29'h0, irq_mask};
            default:               next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            hreadyout <= !(addr_ok && !hwrite);
            hresp     <= 1'b0;
            if (rd_pend)
                hrdata <= next_rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            power_control_two       <= RST_POWER_CONTROL_TWO;
            cycle_end_disable       <= 1'b0;
            reactive_energy_divider <= RST_DIVIDER;
            half_cycle_count        <= RST_HALF_CYCLE_COUNT;
            irq_mask                <= RST_IRQ_MASK;
        end
        else
        begin
            if (wr_ctl2)
                power_control_two <= hwdata[3:0];
            if (wr_ctl1)
                cycle_end_disable <= hwdata[BIT_CYCLE_DIS];
            if (wr_div)
                reactive_energy_divider <= hwdata[7:0];
            if (wr_hcc)
                half_cycle_count <= hwdata[COUNT_W-1:0];
            if (wr_mask)
                irq_mask <= hwdata[FLAG_W-1:0];
        end
    end

    // ==========================================================
    // sample period tick
    logic [SAMPLE_CNT_W-1:0] sample_cnt;
    logic                    sample_tick;

    assign sample_tick = (sample_cnt == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sample_cnt <= '0;
        else if (sample_tick)
            sample_cnt <= '0;
        else
            sample_cnt <= sample_cnt + 1'b1;
    end

    // ==========================================================
    // sample treatment: no-load, scaling, mode sign
    accum_mode_e               mode;
    logic                      tamper_accum_select;
    logic                      absolute_accum_select;
    logic [SAMPLE_W-1:0]       mag;
    logic [SAMPLE_W-1:0]       noload_thr;
    logic                      below;
    logic [7:0]                div_eff;
    logic [SAMPLE_W-1:0]       qmag;
    logic                      neg;
    logic signed [ACC_W-1:0]   delta;
    logic signed [31:0]        pulse_delta;

    assign tamper_accum_select   = power_control_two[BIT_TAMPER_SEL];
    assign absolute_accum_select = power_control_two[BIT_ABSOLUTE_SEL];

    always_comb
    begin
        if (absolute_accum_select)
            mode = MODE_ABSOLUTE;
        else if (tamper_accum_select)
            mode = MODE_TAMPER;
        else
            mode = MODE_SIGNED;
    end

    always_comb
    begin
        case (power_control_two[BIT_NOLOAD_LO+1:BIT_NOLOAD_LO])
            2'h1:    noload_thr = NOLOAD_THR_1;
            2'h2:    noload_thr = NOLOAD_THR_2;
            2'h3:    noload_thr = NOLOAD_THR_3;
            default: noload_thr = '0;
        endcase
    end

    // magnitude of -2^23 still fits as unsigned 24 bits
    assign mag     = power_in.reactive[SAMPLE_W-1] ? SAMPLE_W'(-power_in.reactive)
                                                   : SAMPLE_W'(power_in.reactive);
    assign below   = (mag < noload_thr);
    assign div_eff = (reactive_energy_divider == 8'h00) ? 8'h01 : reactive_energy_divider;
    assign qmag    = mag / {16'h0, div_eff};

    always_comb
    begin
        case (mode)
            MODE_ABSOLUTE: neg = 1'b0;
            MODE_TAMPER:   neg = power_in.reactive[SAMPLE_W-1] ^ power_in.active_negative;
            MODE_SIGNED:   neg = power_in.reactive[SAMPLE_W-1];
            default:       neg = power_in.reactive[SAMPLE_W-1];
        endcase
    end

    // one scaled value feeds both accumulators so their lsb weights match
    always_comb
    begin
        if (below)
            delta = '0;
        else if (neg)
            delta = -$signed({18'h0, qmag});
        else
            delta = $signed({18'h0, qmag});
    end

    // pulse path uses unscaled power with the same mode treatment
    always_comb
    begin
        if (below)
            pulse_delta = '0;
        else if (neg)
            pulse_delta = -$signed({8'h0, mag});
        else
            pulse_delta = $signed({8'h0, mag});
    end

    // ==========================================================
    // main energy accumulator, wraps in two's complement
    logic signed [ACC_W-1:0] acc_base;
    logic signed [ACC_W-1:0] acc_sum;
    logic                    acc_ovf;
    logic                    acc_hf;

    assign acc_base = rd_clear ? {{UPPER_W{1'b0}}, energy_acc[UPPER_LSB-1:0]} : energy_acc;
    assign acc_sum  = acc_base + delta;
    assign acc_ovf  = sample_tick && (acc_base[ACC_W-1] == delta[ACC_W-1])
                      && (acc_sum[ACC_W-1] != acc_base[ACC_W-1]);
    assign acc_hf   = sample_tick && half_full(acc_sum) && !half_full(acc_base);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            energy_acc <= '0;
        else if (sample_tick)
            energy_acc <= acc_sum;
        else if (rd_clear)
            energy_acc <= acc_base;
    end

    // ==========================================================
    // line-cycle accumulation
    line_state_e        line_state;
    logic [COUNT_W-1:0] half_cnt;
    logic               line_end;
    logic               hcc_clear;
    logic signed [ACC_W-1:0] line_sum;

    assign hcc_clear = wr_hcc && !cycle_end_disable;
    assign line_end  = (line_state == LINE_RUN) && zero_cross && !hcc_clear
                       && (half_cycle_count != '0)
                       && (half_cnt + 1'b1 >= half_cycle_count);
    assign line_sum  = line_acc + (sample_tick ? delta : '0);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_state <= LINE_WAIT;
            half_cnt   <= '0;
        end
        else if (hcc_clear)
        begin
            line_state <= LINE_WAIT;
            half_cnt   <= '0;
        end
        else
        begin
            case (line_state)
                LINE_WAIT:
                begin
                    if (zero_cross)
                        line_state <= LINE_RUN;
                    half_cnt <= '0;
                end
                LINE_RUN:
                begin
                    if (line_end)
                        half_cnt <= '0;
                    else if (zero_cross)
                        half_cnt <= half_cnt + 1'b1;
                end
                default:
                begin
                    line_state <= LINE_WAIT;
                    half_cnt   <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_acc    <= '0;
            line_result <= '0;
        end
        else if (hcc_clear)
        begin
            line_acc    <= '0;
            line_result <= '0;
        end
        else if (line_end)
        begin
            line_result <= line_sum[ACC_W-1:UPPER_LSB];
            line_acc    <= '0;
        end
        else if (line_state == LINE_RUN)
            line_acc <= line_sum;
        else
            line_acc <= '0;
    end

    // ==========================================================
    // flags: hardware set wins over a write-zero clear
    logic [FLAG_W-1:0] flag_set;

    assign flag_set = {acc_ovf, acc_hf, line_end && !cycle_end_disable};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_flags <= '0;
        else if (wr_flags)
            irq_flags <= (irq_flags & hwdata[FLAG_W-1:0]) | flag_set;
        else
            irq_flags <= irq_flags | flag_set;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            energy_irq <= 1'b0;
        else
            energy_irq <= |(irq_flags & ~irq_mask);
    end

    // ==========================================================
    // energy pulse and detection outputs
    logic signed [31:0] pulse_acc;
    logic signed [31:0] pulse_sum;

    assign pulse_sum = pulse_acc + pulse_delta;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pulse_acc           <= '0;
            energy_pulse_output <= 1'b0;
        end
        else if (sample_tick && (pulse_sum >= $signed(PULSE_THRESHOLD)))
        begin
            pulse_acc           <= pulse_sum - $signed(PULSE_THRESHOLD);
            energy_pulse_output <= 1'b1;
        end
        else if (sample_tick && (pulse_sum <= -$signed(PULSE_THRESHOLD)))
        begin
            pulse_acc           <= pulse_sum + $signed(PULSE_THRESHOLD);
            energy_pulse_output <= 1'b1;
        end
        else
        begin
            if (sample_tick)
                pulse_acc <= pulse_sum;
            energy_pulse_output <= 1'b0;
        end
    end

    // detection looks at the raw sample whatever the mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reactive_negative <= 1'b0;
            noload_active     <= 1'b0;
        end
        else if (sample_tick)
        begin
            reactive_negative <= power_in.reactive[SAMPLE_W-1];
            noload_active     <= below && (noload_thr != '0);
        end
    end

    // ==========================================================
    // checks
    AST_TICK_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_tick |=> !sample_tick [*8]) else $error("sample ticks too close");
    AST_ACC_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
        (!sample_tick && !rd_clear) |=> $stable(energy_acc)) else $error("acc moved off tick");
    AST_DIV_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        (reactive_energy_divider == 8'h00) |-> (qmag == mag)) else $error("zero divider not one");
    AST_NOLOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        (sample_tick && below) |=> (energy_acc == $past(acc_base))) else $error("no-load added");
    AST_ABS_NONNEG: assert property (@(posedge hclk) disable iff (!hresetn)
        absolute_accum_select |-> !delta[ACC_W-1]) else $error("absolute delta negative");
    AST_CYCLE_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        (line_end && !cycle_end_disable) |=> irq_flags[BIT_CYCLE_END]) else $error("no cycle flag");
    AST_CYCLE_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_flags[BIT_CYCLE_END] && !irq_mask[BIT_CYCLE_END]) |=> energy_irq)
        else $error("cycle irq missing");
    AST_DIS_NOFLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        (line_end && cycle_end_disable && !irq_flags[BIT_CYCLE_END]) |=> !irq_flags[BIT_CYCLE_END])
        else $error("flag despite disable");
    AST_HCC_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        hcc_clear |=> (line_result == '0) && (line_state == LINE_WAIT)) else $error("line not cleared");
    AST_READ_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_clear && !sample_tick) |=> (energy_acc[ACC_W-1:UPPER_LSB] == '0))
        else $error("read did not clear");

endmodule : reactive_energy_accumulator

// [verif/power_source.sv]
// partner model: reactive power source and zero-crossing detector
`timescale 1ns/100ps
module power_source
    import reactive_energy_pkg::*;
#(
    parameter int ZC_PERIOD = 1152,
    parameter int ZC_PHASE  = 600
)(
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic signed [SAMPLE_W-1:0] reactive,
    input  wire logic                       active_negative,
    output power_sample_s                   power_in,
    output logic                            zero_cross
);
    int cnt;

    assign power_in = {reactive, active_negative};

    // crossings sit far from the sample tick so a period edge never meets a tick
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt        <= 0;
            zero_cross <= 1'b0;
        end
        else
        begin
            cnt        <= (cnt == ZC_PERIOD - 1) ? 0 : cnt + 1;
            zero_cross <= (cnt == ZC_PHASE);
        end
    end
endmodule : power_source

// [verif/reactive_energy_accumulator_test.sv]
// self-checking bench of the reactive energy accumulator
`timescale 1ns/100ps
module reactive_energy_accumulator_test;
    import reactive_energy_pkg::*;

    logic                       hclk, hresetn, hwrite, zero_cross, hreadyout, hresp;
    logic                       pulse, rneg, noload, irq, active_negative;
    logic [1:0]                 htrans;
    logic [31:0]                haddr, hwdata, hrdata, q;
    logic signed [SAMPLE_W-1:0] reactive;
    power_sample_s              power_in;
    int                         cyc, pulses, n_fail, n_checks;

    reactive_energy_accumulator #(.PULSE_THRESHOLD(32'h0040_0000)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .power_in(power_in),
        .zero_cross(zero_cross), .energy_pulse_output(pulse), .reactive_negative(rneg),
        .noload_active(noload), .energy_irq(irq));

    power_source partner (.hclk(hclk), .hresetn(hresetn), .reactive(reactive),
        .active_negative(active_negative), .power_in(power_in), .zero_cross(zero_cross));

    // ==========================================================
    // bus and compare tasks
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr  <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // park well away from the sample tick so one window holds exactly one tick
    task automatic align();
        do @(posedge hclk); while (cyc % SAMPLE_CYCLES != 1000);
    endtask : align

    task automatic measure(input logic [3:0] ctrl, input logic [7:0] div,
                           input logic signed [23:0] r, input logic an,
                           input logic [31:0] exp, input int ep);
        bus(1'b1, OFF_POWER_CONTROL_TWO, {28'h0, ctrl});
        bus(1'b1, OFF_DIVIDER, {24'h0, div});
        reactive        <= r;
        active_negative <= an;
        align();
        bus(1'b0, OFF_ENERGY_READ_CLEAR, 32'h0);
        pulses = 0;
        align();
        bus(1'b0, OFF_ENERGY_READ_CLEAR, 32'h0);
        check(q, exp);
        if (ep >= 0)
            check(32'(pulses), 32'(ep));
    endtask : measure

    task automatic wait_irq();
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 8000)
        begin
            @(posedge hclk);
            i++;
        end
        check({31'h0, irq}, 32'h1);
    endtask : wait_irq

    // ==========================================================
    // clock, cycle count, watchdog
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        if (hresetn)
            cyc <= cyc + 1;
        if (pulse === 1'b1)
            pulses = pulses + 1;
    end

    initial
    begin
        #10_000_000;
        n_fail++;
        $display("CHECK FAILED at %0t: timeout", $time);
        summarize();
    end

    // ==========================================================
    // tests
    initial
    begin
        {hresetn, hwrite, active_negative} = 3'h0;
        {htrans, haddr, hwdata} = '0;
        {reactive, cyc, pulses, n_fail, n_checks} = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFF_POWER_CONTROL_TWO, 32'h0); check(q, 32'h0);
        check({31'h0, hresp}, 32'h0);
        bus(1'b0, OFF_DIVIDER, 32'h0); check(q, 32'h1);
        bus(1'b1, 8'h40, 32'hffff_ffff);
        bus(1'b0, 8'h40, 32'h0); check(q, 32'h0);
        measure(4'h0, 8'h01, 24'sh40_0000, 1'b0, 32'h10, 1);
        align();
        bus(1'b0, OFF_ENERGY_UPPER, 32'h0); check(q, 32'h10);
        bus(1'b0, OFF_ENERGY_READ_CLEAR, 32'h0); check(q, 32'h10);
        bus(1'b0, OFF_ENERGY_UPPER, 32'h0); check(q, 32'h0);
        measure(4'h0, 8'h01, 24'shc0_0000, 1'b0, 32'h00ff_fff0, 1);
        measure(4'h0, 8'h02, 24'sh40_0000, 1'b0, 32'h8, 1);
        measure(4'h0, 8'h00, 24'sh40_0000, 1'b0, 32'h10, 1);
        measure(4'h1, 8'h01, 24'sh40_0000, 1'b1, 32'h00ff_fff0, 1);
        measure(4'h1, 8'h01, 24'shc0_0000, 1'b1, 32'h10, 1);
        measure(4'h2, 8'h01, 24'shc0_0000, 1'b0, 32'h10, 1);
        measure(4'h3, 8'h01, 24'shc0_0000, 1'b1, 32'h10, 1);
        check({31'h0, rneg}, 32'h1);
        measure(4'h6, 8'h01, 24'shff_fc18, 1'b0, 32'h0, -1);
        check({31'h0, noload}, 32'h1);
        measure(4'h0, 8'h01, 24'sh40_0000, 1'b0, 32'h10, 1);
        check({31'h0, rneg}, 32'h0);
        check({31'h0, noload}, 32'h0);
        // line periods of four half cycles hold two ticks of +16
        bus(1'b1, OFF_IRQ_MASK, 32'h6);
        bus(1'b1, OFF_HALF_CYCLE_COUNT, 32'h4);
        wait_irq();
        bus(1'b0, OFF_IRQ_REQUEST, 32'h0); check(q, 32'h1);
        bus(1'b0, OFF_LINE_RESULT, 32'h0); check(q, 32'h20);
        bus(1'b1, OFF_IRQ_REQUEST, 32'h0);
        bus(1'b0, OFF_IRQ_REQUEST, 32'h0); check(q, 32'h0);
        check({31'h0, irq}, 32'h0);
        wait_irq();
        bus(1'b0, OFF_LINE_RESULT, 32'h0); check(q, 32'h20);
        bus(1'b1, OFF_POWER_CONTROL_ONE, 32'h1);
        bus(1'b1, OFF_IRQ_REQUEST, 32'h0);
        bus(1'b1, OFF_HALF_CYCLE_COUNT, 32'h4);
        bus(1'b0, OFF_LINE_RESULT, 32'h0); check(q, 32'h20);
        repeat (6000) @(posedge hclk);
        bus(1'b0, OFF_IRQ_REQUEST, 32'h0); check(q, 32'h0);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, OFF_POWER_CONTROL_ONE, 32'h0);
        bus(1'b1, OFF_HALF_CYCLE_COUNT, 32'h4);
        bus(1'b0, OFF_LINE_RESULT, 32'h0); check(q, 32'h0);
        wait_irq();
        bus(1'b0, OFF_LINE_RESULT, 32'h0); check(q, 32'h20);
        summarize();
    end
endmodule : reactive_energy_accumulator_test
